/* File: dcic_pkg.sv */
// Package: register map, source bits, timing and bus carriers
package dcic_pkg;
  localparam int unsigned NSRC = 11;
  localparam int unsigned AW = 5;
  localparam int unsigned DW = 16;

  // Register word addresses
  localparam logic [4:0] A_SUB_PEND = 5'h00;
  localparam logic [4:0] A_SUB_EN = 5'h01;
  localparam logic [4:0] A_SUB_CLR = 5'h02;
  localparam logic [4:0] A_SUB_LV0 = 5'h03;
  localparam logic [4:0] A_SUB_LV1 = 5'h04;
  localparam logic [4:0] A_SUB_LV2 = 5'h05;
  localparam logic [4:0] A_MAIN_PEND = 5'h06;
  localparam logic [4:0] A_MAIN_EN = 5'h07;
  localparam logic [4:0] A_MAIN_CLR = 5'h08;
  localparam logic [4:0] A_SUB_RST = 5'h09;
  localparam logic [4:0] A_INT_NUM = 5'h0a;
  localparam logic [4:0] A_EOI = 5'h0b;
  localparam logic [4:0] A_TMR0 = 5'h0c;

  // Source bit positions
  localparam int unsigned B_EXT = 0;
  localparam int unsigned B_MIDI_IN = 3;
  localparam int unsigned B_DMA = 4;
  localparam int unsigned B_BELL = 5;
  localparam int unsigned B_TMR_A = 6;
  localparam int unsigned B_MIDI_OUT = 9;
  localparam int unsigned B_SAMPLE = 10;
  localparam int unsigned B_SHARED_LV = 7;
  localparam logic [10:0] PEND_RSV = 11'h006;
  localparam logic [10:0] BELL_MASK = 11'h020;

  // Timer field layout and interrupt number layout
  localparam int unsigned NTMR = 3;
  localparam int unsigned TCNT_HI = 7;
  localparam int unsigned TCTL_LO = 8;
  localparam int unsigned TCTL_HI = 10;
  localparam logic [7:0] TCNT_MAX = 8'hff;
  localparam int unsigned NUM_LO = 3;
  localparam int unsigned EOI_LO = 1;

  // Reset values
  localparam logic [10:0] RST_EN = 11'h000;
  localparam logic [7:0] RST_LV = 8'h00;
  localparam logic RST_SUB_RUN = 1'b0;

  // Main CPU clock is chip clock divided by this figure
  localparam int unsigned MC_DIV = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dcic_req_t;

  typedef struct packed {
    logic midi_in_empty;
    logic midi_out_empty;
    logic dma_done;
    logic sample_tick;
  } dcic_src_t;
endpackage

/* File: dcic_top.sv */
// Dual processor interrupt controller with timers and sub CPU reset
// Contract
// RULE_01: Sub pending 11 bits, bits 1-2 reserved
// RULE_02: MIDI in bit set on data, auto-clears empty
// RULE_03: Handler drains MIDI input FIFO to empty
// RULE_04: Doorbell bit writable one-only from both CPUs
// RULE_05: MIDI out bit set empty, clears on write
// RULE_06: Bits: DMA 4, timers 6-8, sample 10
// RULE_07: Per-CPU enable gates each request
// RULE_08: Clear register resets bits written one
// RULE_09: Three level registers form 3-bit level code
// RULE_10: Level bit 7 shared by requests 7-10
// RULE_11: External request level comes from level pins
// RULE_12: Main pending mirrors sources and auto-clear
// RULE_13: Main irq low one main clock on request
// RULE_14: Main CPU gets only pulse, no level
// RULE_15: Sub reset control, main CPU writes only
// RULE_16: Interrupt number register, upper five bits used
// RULE_17: Sub CPU writes end-of-interrupt when done
// RULE_18: Number and EOI registers sub side only
// RULE_19: Timer request at 8-bit counter wrap
// RULE_20: Level outputs show best qualified request
// RULE_21: Main pulse only on enabled set transition
module dcic_top
  import dcic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sub CPU register port
  input wire dcic_req_t sub_req,
  output logic [DW-1:0] sub_rdata,
  // Main CPU register port
  input wire dcic_req_t main_req,
  output logic [DW-1:0] main_rdata,
  // Event sources on the chip clock
  input wire dcic_src_t src,
  // Pins
  input wire logic external_irq_in_n,
  input wire logic ext_level_pin0_n,
  input wire logic ext_level_pin1_n,
  input wire logic ext_level_pin2_n,
  // Interrupt outputs and sub CPU reset
  output logic [2:0] sub_irq_level,
  output logic sub_irq_valid,
  output logic main_cpu_irq_n,
  output logic sub_cpu_reset_n
);

  function automatic logic [6:0] presc_mask(input logic [2:0] ctl);
    presc_mask = 7'((8'h01 << ctl) - 8'h01);
  endfunction

  function automatic logic sub_wr(input dcic_req_t r, input logic [4:0] a);
    sub_wr = r.wr && (r.addr == a);
  endfunction

  // Pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge clk) begin
    pin_s1_r <= {external_irq_in_n, ext_level_pin2_n,
                 ext_level_pin1_n, ext_level_pin0_n};
    pin_s2_r <= pin_s1_r;
  end
  logic ext_req;
  logic [2:0] ext_lvl;
  assign ext_req = ~pin_s2_r[3];
  assign ext_lvl = ~pin_s2_r[2:0];

  // Registers
  logic [10:0] sub_pend_r;
  logic [10:0] sub_pend_nxt;
  logic [10:0] main_pend_r;
  logic [10:0] main_pend_nxt;
  logic [10:0] sub_en_r;
  logic [10:0] main_en_r;
  logic [7:0] lv_r [3];
  logic [7:0] tcnt_r [NTMR];
  logic [2:0] tctl_r [NTMR];
  logic [6:0] samp_cnt_r;
  logic in_empty_r;
  logic out_empty_r;
  logic sub_run_r;
  logic [4:0] num_r;
  logic num_hold_r;

  // Timers step on sample ticks by prescale and raise at wrap
  logic [NTMR-1:0] tinc;
  logic [NTMR-1:0] twrap;
  always_comb begin
    for (int i = 0; i < NTMR; i++) begin
      tinc[i] = src.sample_tick &&
                ((samp_cnt_r & presc_mask(tctl_r[i])) == 7'h00);
      twrap[i] = tinc[i] && (tcnt_r[i] == TCNT_MAX); // [RULE_19]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      samp_cnt_r <= 7'h00;
    end else if (src.sample_tick) begin
      samp_cnt_r <= samp_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NTMR; i++) begin
        tcnt_r[i] <= 8'h00;
        tctl_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NTMR; i++) begin
        if (sub_wr(sub_req, A_TMR0 + 5'(i))) begin
          tcnt_r[i] <= sub_req.wdata[TCNT_HI:0];
          tctl_r[i] <= sub_req.wdata[TCTL_HI:TCTL_LO];
        end else if (sub_wr(main_req, A_TMR0 + 5'(i))) begin
          tcnt_r[i] <= main_req.wdata[TCNT_HI:0];
          tctl_r[i] <= main_req.wdata[TCTL_HI:TCTL_LO];
        end else if (tinc[i]) begin
          tcnt_r[i] <= tcnt_r[i] + 8'h01;
        end
      end
    end
  end

  // Source events and automatic clears
  logic [10:0] ev;
  logic [10:0] auto_clr;
  logic [10:0] bell;
  always_comb begin
    ev = '0;
    auto_clr = '0;
    ev[B_EXT] = ext_req; // [RULE_01]
    ev[B_MIDI_IN] = in_empty_r && !src.midi_in_empty; // [RULE_02]
    auto_clr[B_MIDI_IN] = src.midi_in_empty; // [RULE_02]
    ev[B_DMA] = src.dma_done; // [RULE_06]
    ev[B_TMR_A +: NTMR] = twrap; // [RULE_06]
    ev[B_MIDI_OUT] = !out_empty_r && src.midi_out_empty; // [RULE_05]
    auto_clr[B_MIDI_OUT] = !src.midi_out_empty; // [RULE_05]
    ev[B_SAMPLE] = src.sample_tick; // [RULE_06]
    bell = '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      in_empty_r <= 1'b1;
      out_empty_r <= 1'b1;
    end else begin
      in_empty_r <= src.midi_in_empty;
      out_empty_r <= src.midi_out_empty;
    end
  end

  // Pending next state; events win over clears
  logic [10:0] sub_clr;
  logic [10:0] main_clr;
  logic [10:0] sub_bell;
  logic [10:0] main_bell;
  always_comb begin
    sub_clr = '0;
    main_clr = '0;
    sub_bell = bell;
    main_bell = bell;
    if (sub_wr(sub_req, A_SUB_CLR)) sub_clr = sub_clr | sub_req.wdata[10:0];
    if (sub_wr(main_req, A_SUB_CLR)) sub_clr = sub_clr | main_req.wdata[10:0];
    if (sub_wr(sub_req, A_MAIN_CLR)) main_clr = main_clr | sub_req.wdata[10:0];
    if (sub_wr(main_req, A_MAIN_CLR)) begin
      main_clr = main_clr | main_req.wdata[10:0]; // [RULE_08]
    end
    if (sub_wr(sub_req, A_SUB_PEND)) begin
      sub_bell = sub_bell | (sub_req.wdata[10:0] & BELL_MASK); // [RULE_04]
    end
    if (sub_wr(main_req, A_SUB_PEND)) begin
      sub_bell = sub_bell | (main_req.wdata[10:0] & BELL_MASK); // [RULE_04]
    end
    if (sub_wr(sub_req, A_MAIN_PEND)) begin
      main_bell = main_bell | (sub_req.wdata[10:0] & BELL_MASK); // [RULE_04]
    end
    if (sub_wr(main_req, A_MAIN_PEND)) begin
      main_bell = main_bell | (main_req.wdata[10:0] & BELL_MASK); // [RULE_04]
    end
    sub_pend_nxt = ((sub_pend_r & ~(sub_clr | auto_clr)) | ev | sub_bell)
                   & ~PEND_RSV; // [RULE_01] [RULE_08]
    main_pend_nxt = ((main_pend_r & ~(main_clr | auto_clr)) | ev | main_bell)
                    & ~PEND_RSV; // [RULE_12]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sub_pend_r <= '0;
      main_pend_r <= '0;
    end else begin
      sub_pend_r <= sub_pend_nxt;
      main_pend_r <= main_pend_nxt;
    end
  end

  // Enable and level registers; sub port wins a same-cycle write
  always_ff @(posedge clk) begin
    if (srst) begin
      sub_en_r <= RST_EN;
      main_en_r <= RST_EN;
      for (int k = 0; k < 3; k++) lv_r[k] <= RST_LV;
    end else begin
      if (sub_wr(sub_req, A_SUB_EN)) sub_en_r <= sub_req.wdata[10:0];
      else if (sub_wr(main_req, A_SUB_EN)) sub_en_r <= main_req.wdata[10:0];
      if (sub_wr(sub_req, A_MAIN_EN)) main_en_r <= sub_req.wdata[10:0];
      else if (sub_wr(main_req, A_MAIN_EN)) main_en_r <= main_req.wdata[10:0];
      for (int k = 0; k < 3; k++) begin
        if (sub_wr(sub_req, A_SUB_LV0 + 5'(k))) begin
          lv_r[k] <= sub_req.wdata[7:0]; // [RULE_09]
        end else if (sub_wr(main_req, A_SUB_LV0 + 5'(k))) begin
          lv_r[k] <= main_req.wdata[7:0]; // [RULE_09]
        end
      end
    end
  end

  // Sub reset control, main port only
  always_ff @(posedge clk) begin
    if (srst) begin
      sub_run_r <= RST_SUB_RUN;
    end else if (sub_wr(main_req, A_SUB_RST)) begin
      sub_run_r <= main_req.wdata[0]; // [RULE_15]
    end
  end
  assign sub_cpu_reset_n = sub_run_r; // [RULE_15]

  // Level code per source and highest qualified request
  logic [2:0] lvl [NSRC];
  logic [10:0] sub_q;
  logic best_ok;
  logic [2:0] best_lvl;
  logic [4:0] best_idx;
  always_comb begin
    sub_q = sub_pend_r & sub_en_r; // [RULE_07]
    best_ok = 1'b0;
    best_lvl = 3'h0;
    best_idx = 5'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (i == B_EXT) begin
        lvl[i] = ext_lvl; // [RULE_11]
      end else if (i >= B_SHARED_LV) begin
        lvl[i] = {lv_r[2][B_SHARED_LV], lv_r[1][B_SHARED_LV],
                  lv_r[0][B_SHARED_LV]}; // [RULE_10]
      end else begin
        lvl[i] = {lv_r[2][i], lv_r[1][i], lv_r[0][i]}; // [RULE_09]
      end
      if (sub_q[i] && (!best_ok || lvl[i] > best_lvl)) begin
        best_ok = 1'b1; // [RULE_20]
        best_lvl = lvl[i];
        best_idx = 5'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sub_irq_valid <= 1'b0;
      sub_irq_level <= 3'h0;
    end else begin
      sub_irq_valid <= best_ok; // [RULE_20]
      sub_irq_level <= best_ok ? best_lvl : 3'h0;
    end
  end

  // Delivered number held until end of interrupt from sub side
  logic eoi_wr;
  assign eoi_wr = sub_wr(sub_req, A_EOI) &&
                  (sub_req.wdata[7:EOI_LO] != 7'h00); // [RULE_18]
  always_ff @(posedge clk) begin
    if (srst) begin
      num_r <= 5'h00;
      num_hold_r <= 1'b0;
    end else if (eoi_wr) begin
      num_hold_r <= 1'b0;
    end else if (best_ok && !num_hold_r) begin
      num_r <= best_idx; // [RULE_16]
      num_hold_r <= 1'b1;
    end
  end

  // Main CPU clock enable and one-period low pulse
  logic [1:0] mc_div_r;
  logic mc_en;
  logic mc_req_r;
  logic mc_new;
  assign mc_en = (mc_div_r == 2'(MC_DIV - 1));
  assign mc_new = |(main_pend_nxt & ~main_pend_r & main_en_r); // [RULE_21]
  always_ff @(posedge clk) begin
    if (srst) begin
      mc_div_r <= 2'h0;
    end else begin
      mc_div_r <= mc_en ? 2'h0 : mc_div_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mc_req_r <= 1'b0;
      main_cpu_irq_n <= 1'b1;
    end else begin
      if (mc_new) mc_req_r <= 1'b1;
      else if (mc_en && main_cpu_irq_n) mc_req_r <= 1'b0;
      if (mc_en) begin
        main_cpu_irq_n <= !(mc_req_r && main_cpu_irq_n); // [RULE_13] [RULE_14]
      end
    end
  end

  // Read data one cycle after the strobe
  function automatic logic [DW-1:0] rd_mux(input logic [4:0] a,
                                            input logic from_sub);
    rd_mux = '0;
    case (a)
      A_SUB_PEND: rd_mux = DW'(sub_pend_r);
      A_SUB_EN: rd_mux = DW'(sub_en_r);
      A_SUB_LV0: rd_mux = DW'({lv_r[0][7:1], ext_lvl[0]});
      A_SUB_LV1: rd_mux = DW'({lv_r[1][7:1], ext_lvl[1]});
      A_SUB_LV2: rd_mux = DW'({lv_r[2][7:1], ext_lvl[2]});
      A_MAIN_PEND: rd_mux = DW'(main_pend_r);
      A_MAIN_EN: rd_mux = DW'(main_en_r);
      A_SUB_RST: rd_mux = DW'(sub_run_r);
      A_INT_NUM: rd_mux = from_sub ? DW'({num_r, 3'h0}) : '0; // [RULE_18]
      default: begin
        for (int i = 0; i < NTMR; i++) begin
          if (a == A_TMR0 + 5'(i)) rd_mux = DW'({tctl_r[i], tcnt_r[i]});
        end
      end
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      sub_rdata <= '0;
      main_rdata <= '0;
    end else begin
      sub_rdata <= sub_req.rd ? rd_mux(sub_req.addr, 1'b1) : '0;
      main_rdata <= main_req.rd ? rd_mux(main_req.addr, 1'b0) : '0;
    end
  end

  // Checks
  property p_rsv;
    @(posedge clk) disable iff (srst)
      (sub_pend_r[2:1] == 2'b00) && (main_pend_r[2:1] == 2'b00);
  endproperty
  a_rsv: assert property (p_rsv) // [RULE_01]
    else $error("reserved pending bits set");

  property p_bell;
    @(posedge clk) disable iff (srst)
      (sub_req.wr && sub_req.addr == A_MAIN_PEND && sub_req.wdata[B_BELL])
      |=> main_pend_r[B_BELL];
  endproperty
  a_bell: assert property (p_bell) // [RULE_04]
    else $error("doorbell not set in main pending");

  property p_clr;
    @(posedge clk) disable iff (srst)
      (sub_req.wr && sub_req.addr == A_SUB_CLR && sub_req.wdata[B_DMA]
       && !src.dma_done) |=> !sub_pend_r[B_DMA];
  endproperty
  a_clr: assert property (p_clr) // [RULE_08]
    else $error("clear did not reset pending bit");

  property p_min;
    @(posedge clk) disable iff (srst)
      src.midi_in_empty |=> !sub_pend_r[B_MIDI_IN] && !main_pend_r[B_MIDI_IN];
  endproperty
  a_min: assert property (p_min) // [RULE_02]
    else $error("midi input request not withdrawn");

  property p_mout;
    @(posedge clk) disable iff (srst)
      $rose(src.midi_out_empty) |=> sub_pend_r[B_MIDI_OUT] ##1
      (src.midi_out_empty || !sub_pend_r[B_MIDI_OUT]);
  endproperty
  a_mout: assert property (p_mout) // [RULE_05]
    else $error("midi output request wrong");

  property p_tick;
    @(posedge clk) disable iff (srst)
      src.sample_tick |=> sub_pend_r[B_SAMPLE] && main_pend_r[B_SAMPLE];
  endproperty
  a_tick: assert property (p_tick) // [RULE_06]
    else $error("sample request missing");

  property p_pulse;
    @(posedge clk) disable iff (srst)
      $fell(main_cpu_irq_n) |-> !main_cpu_irq_n [*4] ##1 main_cpu_irq_n;
  endproperty
  a_pulse: assert property (p_pulse) // [RULE_13]
    else $error("main irq pulse not one main clock");

  property p_valid;
    @(posedge clk) disable iff (srst)
      ##1 (sub_irq_valid == $past(|(sub_pend_r & sub_en_r)));
  endproperty
  a_valid: assert property (p_valid) // [RULE_20]
    else $error("sub irq valid mismatch");

  property p_rst;
    @(posedge clk) disable iff (srst)
      (sub_req.wr && sub_req.addr == A_SUB_RST &&
       !(main_req.wr && main_req.addr == A_SUB_RST))
      |=> $stable(sub_cpu_reset_n);
  endproperty
  a_rst: assert property (p_rst) // [RULE_15]
    else $error("sub port changed reset control");

  property p_wrap;
    @(posedge clk) disable iff (srst)
      twrap[0] |=> sub_pend_r[B_TMR_A] ##1 1'b1;
  endproperty
  a_wrap: assert property (p_wrap) // [RULE_19]
    else $error("timer wrap request missing");

endmodule

/* File: dcic_midi_model.sv */
// MIDI input and output FIFO occupancy model driving the empty flags
module dcic_midi_model
  import dcic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // FIFO traffic
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic push_out,
  input wire logic pop_out,
  // Empty flags
  output logic in_empty,
  output logic out_empty
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] in_cnt_r;
  logic [2:0] out_cnt_r;

  // Input FIFO holds four bytes and drops on full
  always_ff @(posedge clk) begin
    if (srst) begin
      in_cnt_r <= 3'h0;
    end else if (push_in && in_cnt_r < 3'h4) begin
      in_cnt_r <= in_cnt_r + 3'h1;
    end else if (pop_in && in_cnt_r != 3'h0) begin
      in_cnt_r <= in_cnt_r - 3'h1;
    end
  end

  // Output FIFO starts with one byte queued
  always_ff @(posedge clk) begin
    if (srst) begin
      out_cnt_r <= 3'h1;
    end else if (push_out && out_cnt_r < 3'h4) begin
      out_cnt_r <= out_cnt_r + 3'h1;
    end else if (pop_out && out_cnt_r != 3'h0) begin
      out_cnt_r <= out_cnt_r - 3'h1;
    end
  end

  assign in_empty = (in_cnt_r == 3'h0);
  assign out_empty = (out_cnt_r == 3'h0);
endmodule

/* File: test_dual_cpu_interrupt_controller.sv */
// Testbench for the dual processor interrupt controller
module test_dual_cpu_interrupt_controller
  import dcic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic srst;
  dcic_req_t sub_req;
  dcic_req_t main_req;
  logic [DW-1:0] sub_rdata;
  logic [DW-1:0] main_rdata;
  dcic_src_t src;
  logic ext_n;
  logic [2:0] lvl_n;
  logic [2:0] sub_irq_level;
  logic sub_irq_valid;
  logic main_cpu_irq_n;
  logic sub_cpu_reset_n;
  logic [5:0] evt;
  logic in_e;
  logic out_e;
  int n_fail;
  int n_tests;
  int c;

  assign src = '{midi_in_empty: in_e, midi_out_empty: out_e,
                 dma_done: evt[0], sample_tick: evt[1]};

  dcic_top u_dcic_top (
    .clk(clk),
    .srst(srst),
    .sub_req(sub_req),
    .sub_rdata(sub_rdata),
    .main_req(main_req),
    .main_rdata(main_rdata),
    .src(src),
    .external_irq_in_n(ext_n),
    .ext_level_pin0_n(lvl_n[0]),
    .ext_level_pin1_n(lvl_n[1]),
    .ext_level_pin2_n(lvl_n[2]),
    .sub_irq_level(sub_irq_level),
    .sub_irq_valid(sub_irq_valid),
    .main_cpu_irq_n(main_cpu_irq_n),
    .sub_cpu_reset_n(sub_cpu_reset_n)
  );

  dcic_midi_model u_dcic_midi_model (
    .clk(clk),
    .srst(srst),
    .push_in(evt[2]),
    .pop_in(evt[3]),
    .push_out(evt[4]),
    .pop_out(evt[5]),
    .in_empty(in_e),
    .out_empty(out_e)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register cycle; read data taken in the cycle after the strobe
  task automatic bus(input bit m, input bit w, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    dcic_req_t r;
    r = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    if (m) begin
      main_req <= r;
    end else begin
      sub_req <= r;
    end
    @(posedge clk);
    main_req <= '0;
    sub_req <= '0;
    #1;
    q = m ? main_rdata : sub_rdata;
  endtask

  task automatic wr(input bit m, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(m, 1'b1, a, d, q);
  endtask

  task automatic rchk(input bit m, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(m, 1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask

  // Events: 0 dma, 1 tick, 2 push in, 3 pop in, 4 push out, 5 pop out
  task automatic ev(input int k);
    @(posedge clk);
    evt[k] <= 1'b1;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic clr_all;
    wr(1'b0, A_SUB_CLR, 16'h07ff);
    wr(1'b1, A_MAIN_CLR, 16'h07ff);
  endtask

  task automatic count_low(output int n);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (main_cpu_irq_n === 1'b0) begin
        n++;
      end
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sub_req = '0;
    main_req = '0;
    ext_n = 1'b1;
    lvl_n = 3'h7;
    evt = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    // Reset state and unmapped read
    rchk(1'b0, A_SUB_PEND, 16'h0000);
    rchk(1'b0, 5'h1f, 16'h0000);
    chk(sub_cpu_reset_n, 16'h0000);
    chk(main_cpu_irq_n, 16'h0001);
    // Doorbell and clear
    wr(1'b0, A_SUB_PEND, 16'h07ff);
    rchk(1'b0, A_SUB_PEND, 16'h0020);
    wr(1'b0, A_SUB_PEND, 16'h0000);
    rchk(1'b0, A_SUB_PEND, 16'h0020);
    wr(1'b0, A_MAIN_PEND, 16'h0020);
    rchk(1'b1, A_MAIN_PEND, 16'h0020);
    wr(1'b0, A_SUB_CLR, 16'h0000);
    rchk(1'b0, A_SUB_PEND, 16'h0020);
    clr_all();
    rchk(1'b0, A_SUB_PEND, 16'h0000);
    rchk(1'b1, A_MAIN_PEND, 16'h0000);
    wr(1'b1, A_SUB_PEND, 16'h0020);
    rchk(1'b0, A_SUB_PEND, 16'h0020);
    clr_all();
    // Source bits
    ev(0);
    rchk(1'b0, A_SUB_PEND, 16'h0010);
    rchk(1'b1, A_MAIN_PEND, 16'h0010);
    clr_all();
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, A_TMR0 + 5'(i), 16'h00fe);
      ev(1);
      rchk(1'b0, A_SUB_PEND, 16'h0400);
      clr_all();
      ev(1);
      rchk(1'b0, A_SUB_PEND, 16'h0400 | (16'h0040 << i));
      clr_all();
    end
    // MIDI input drained byte by byte, output emptied then refilled
    ev(2);
    ev(2);
    rchk(1'b0, A_SUB_PEND, 16'h0008);
    rchk(1'b1, A_MAIN_PEND, 16'h0008);
    ev(3);
    rchk(1'b0, A_SUB_PEND, 16'h0008);
    ev(3);
    rchk(1'b0, A_SUB_PEND, 16'h0000);
    rchk(1'b1, A_MAIN_PEND, 16'h0000);
    ev(5);
    rchk(1'b0, A_SUB_PEND, 16'h0200);
    ev(4);
    rchk(1'b0, A_SUB_PEND, 16'h0000);
    // Sub levels: dma 5, sample via shared bit 6, external pin 7
    wr(1'b0, A_SUB_LV0, 16'h0010);
    wr(1'b0, A_SUB_LV1, 16'h0080);
    wr(1'b0, A_SUB_LV2, 16'h0090);
    rchk(1'b0, A_SUB_LV1, 16'h0080);
    ev(0);
    chk(sub_irq_valid, 16'h0000);
    wr(1'b0, A_SUB_EN, 16'h0411);
    settle();
    chk(sub_irq_valid, 16'h0001);
    chk(sub_irq_level, 16'h0005);
    rchk(1'b0, A_INT_NUM, 16'h0020);
    rchk(1'b1, A_INT_NUM, 16'h0000);
    ev(1);
    chk(sub_irq_level, 16'h0006);
    lvl_n <= 3'h0;
    ext_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(sub_irq_level, 16'h0007);
    rchk(1'b0, A_SUB_LV0, 16'h0011);
    ext_n <= 1'b1;
    repeat (6) @(posedge clk);
    clr_all();
    settle();
    chk(sub_irq_valid, 16'h0000);
    chk(sub_irq_level, 16'h0000);
    wr(1'b0, A_EOI, 16'h0002);
    // Main pulse: once per new enabled request
    wr(1'b1, A_MAIN_EN, 16'h0010);
    fork
      ev(0);
      count_low(c);
    join
    chk(16'(c), 16'(MC_DIV));
    fork
      ev(0);
      count_low(c);
    join
    chk(16'(c), 16'h0000);
    clr_all();
    wr(1'b1, A_MAIN_EN, 16'h0000);
    fork
      ev(0);
      count_low(c);
    join
    chk(16'(c), 16'h0000);
    clr_all();
    // Sub CPU reset control writable from the main port only
    wr(1'b0, A_SUB_RST, 16'h0001);
    settle();
    chk(sub_cpu_reset_n, 16'h0000);
    wr(1'b1, A_SUB_RST, 16'h0001);
    settle();
    chk(sub_cpu_reset_n, 16'h0001);
    rchk(1'b1, A_SUB_RST, 16'h0001);
    tally_and_finish();
  end
endmodule
